// ===== include/charger_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH

// -----------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------
`define REG_CONTROL_OFS        4'h0
`define REG_STATUS_OFS         4'h4
`define REG_SAFETY_OFS         4'h8

// -----------------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------------
`define CTRL_EN_STAT           0
`define CTRL_TIMER_MODE        1
`define CTRL_BOOST_PIN_EN      2
`define CTRL_SW_BOOST          3
`define CTRL_LIMIT_SEL         4
`define CTRL_TIMER_RESTART     5
`define CTRL_RESET             6'h01

// -----------------------------------------------------------------------
// status register fields
// -----------------------------------------------------------------------
`define STAT_CHARGING          0
`define STAT_PULSE             1
`define STAT_TIMER_EXPIRED     2
`define STAT_BOOST             3
`define STAT_LIMIT_500         4
`define STAT_CHARGE_DIS        5
`define STAT_SAFETY_RST        6
`define STAT_SAFETY_LOCK       7

// -----------------------------------------------------------------------
// safety limit register and bus answers
// -----------------------------------------------------------------------
`define SAFETY_RESET           8'h00
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define CLK_MHZ                250
`define FAULT_PULSE_US         128
`define SAFETY_LONG_MIN        15
`define SAFETY_SHORT_S         32
`define FAULT_PULSE_CYCLES     (`FAULT_PULSE_US * `CLK_MHZ)
`define SAFETY_LONG_CYCLES     (64'd60 * `SAFETY_LONG_MIN * `CLK_MHZ * 64'd1000000)
`define SAFETY_SHORT_CYCLES    (64'd1 * `SAFETY_SHORT_S * `CLK_MHZ * 64'd1000000)

`endif

// ===== include/charger_pkg.sv
// types shared by the charger pin control logic
package charger_pkg;

  typedef enum logic [0:0]
  {
    timer_long  = 1'b0,
    timer_short = 1'b1
  } timer_mode_t;

  typedef enum logic [0:0]
  {
    pulse_idle = 1'b0,
    pulse_busy = 1'b1
  } pulse_state_t;

  typedef enum logic [1:0]
  {
    sel_control = 2'b00,
    sel_status  = 2'b01,
    sel_safety  = 2'b10,
    sel_none    = 2'b11
  } reg_sel_t;

endpackage

// ===== logic/sync_2ff.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module sync_2ff
#(
  parameter int WIDTH = 3
)
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

// ===== logic/charger_pin_control.sv
// charger pin control logic with its axi4-lite register slave
`timescale 1ns/1ns
`include "charger_defs.svh"

module charger_pin_control
#(
  parameter logic [15:0] PULSE_CYCLES = 16'(`FAULT_PULSE_CYCLES),
  parameter logic [37:0] LONG_CYCLES  = 38'(`SAFETY_LONG_CYCLES),
  parameter logic [37:0] SHORT_CYCLES = 38'(`SAFETY_SHORT_CYCLES)
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // pins from the host
  input  wire logic        charge_disable_in,
  input  wire logic        boost_or_limit_select,
  input  wire logic        safety_limit_reset_in,
  // charge status open-drain pin
  output logic             stat_out,
  output logic             stat_oe,
  // core charger state
  input  wire logic        charge_in_progress,
  input  wire logic        fault_in,
  // controls to the charger core
  output logic             charge_enable,
  output logic             vbus_hiz,
  output logic             boost_mode,
  output logic             limit_500ma,
  output logic             timer_expired,
  output logic [7:0]       safety_limit
);

  // -----------------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------------
  function automatic charger_pkg::reg_sel_t reg_decode(input logic [3:0] a);
    charger_pkg::reg_sel_t s;
    s = charger_pkg::sel_none;
    case (a)
      `REG_CONTROL_OFS: s = charger_pkg::sel_control;
      `REG_STATUS_OFS:  s = charger_pkg::sel_status;
      `REG_SAFETY_OFS:  s = charger_pkg::sel_safety;
      default:          s = charger_pkg::sel_none;
    endcase
    return s;
  endfunction

  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       cd_sync;
  logic       sel_sync;
  logic       safety_limit_reset_in_sync;

  sync_2ff #(.WIDTH(3)) u_pin_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({safety_limit_reset_in, boost_or_limit_select,
                charge_disable_in}),
    .sync_out (pins_sync)
  );

  assign cd_sync    = pins_sync[0];
  assign sel_sync   = pins_sync[1];
  assign safety_limit_reset_in_sync = pins_sync[2];

  // -----------------------------------------------------------------------
  // write channel
  // -----------------------------------------------------------------------
  logic                  aw_full;
  logic [3:0]            aw_addr;
  logic                  w_full;
  logic [31:0]           w_data;
  logic                  w_lane0;
  logic                  do_write;
  charger_pkg::reg_sel_t wr_sel;
  logic                  ctrl_wr;
  logic                  status_wr;
  logic                  safety_wr;
  logic                  other_wr;

  assign awready   = !aw_full && !bvalid;
  assign wready    = !w_full && !bvalid;
  assign do_write  = aw_full && w_full && !bvalid;
  assign wr_sel    = reg_decode(aw_addr);
  assign ctrl_wr   = do_write && w_lane0
                     && wr_sel == charger_pkg::sel_control;
  assign status_wr = do_write && w_lane0
                     && wr_sel == charger_pkg::sel_status;
  assign other_wr  = do_write && (wr_sel == charger_pkg::sel_control
                     || wr_sel == charger_pkg::sel_status);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= 4'h0;
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= {awaddr[3:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        w_full  <= 1'b1;
        w_data  <= wdata;
        w_lane0 <= wstrb[0];
      end
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wr_sel == charger_pkg::sel_none) ? `RESP_SLVERR
                                                     : `RESP_OKAY;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------------
  logic [5:0]               control;
  logic                     en_stat;
  charger_pkg::timer_mode_t timer_mode;
  logic                     boost_pin_en;
  logic                     sw_boost;
  logic                     limit_sel;
  logic                     timer_restart;

  assign en_stat       = control[`CTRL_EN_STAT];
  assign timer_mode    = charger_pkg::timer_mode_t'(control[`CTRL_TIMER_MODE]);
  assign boost_pin_en  = control[`CTRL_BOOST_PIN_EN];
  assign sw_boost      = control[`CTRL_SW_BOOST];
  assign limit_sel     = control[`CTRL_LIMIT_SEL];
  assign timer_restart = ctrl_wr && w_data[`CTRL_TIMER_RESTART];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control <= `CTRL_RESET;
    else if (ctrl_wr)
      control <= {1'b0, w_data[4:0]};
  end

  // -----------------------------------------------------------------------
  // safety limit register and lock
  // -----------------------------------------------------------------------
  logic safety_locked;

  assign safety_wr = do_write && w_lane0 && safety_limit_reset_in_sync && !safety_locked
                     && wr_sel == charger_pkg::sel_safety;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      safety_limit  <= `SAFETY_RESET;
      safety_locked <= 1'b0;
    end
    else if (!safety_limit_reset_in_sync)
    begin
      safety_limit  <= `SAFETY_RESET;
      safety_locked <= 1'b0;
    end
    else
    begin
      if (safety_wr)
        safety_limit <= w_data[7:0];
      if (other_wr)
        safety_locked <= 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // safety timer
  // -----------------------------------------------------------------------
  logic [37:0]              timer_count;
  logic [37:0]              timer_last;
  logic                     timer_done;
  logic                     timer_clear;
  logic                     timer_hit;
  logic                     expired_clear;
  charger_pkg::timer_mode_t mode_seen;

  assign timer_last    = (timer_mode == charger_pkg::timer_short)
                         ? SHORT_CYCLES - 38'd1 : LONG_CYCLES - 38'd1;
  // only the long mode lets charge disable restart the count
  assign timer_clear   = timer_restart || timer_mode != mode_seen
                         || (timer_mode == charger_pkg::timer_long
                             && cd_sync);
  assign timer_hit     = !timer_clear && !timer_done && charge_in_progress
                         && timer_count >= timer_last;
  assign expired_clear = status_wr && w_data[`STAT_TIMER_EXPIRED];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_count   <= 38'h00_0000_0000;
      timer_done    <= 1'b0;
      timer_expired <= 1'b0;
      mode_seen     <= charger_pkg::timer_long;
    end
    else
    begin
      mode_seen <= timer_mode;
      if (timer_clear)
      begin
        timer_count <= 38'h00_0000_0000;
        timer_done  <= 1'b0;
      end
      else if (timer_hit)
        timer_done <= 1'b1;
      else if (charge_in_progress && !timer_done)
        timer_count <= timer_count + 38'd1;
      // a new expiry wins over a clear in the same cycle
      timer_expired <= timer_hit || (timer_expired && !expired_clear);
    end
  end

  // -----------------------------------------------------------------------
  // fault pulse on the status pin
  // -----------------------------------------------------------------------
  charger_pkg::pulse_state_t pulse_state;
  charger_pkg::pulse_state_t next_pulse_state;
  logic [15:0]               pulse_count;
  logic                      fault_prev;
  logic                      fault_event;
  logic                      pulse_end;

  assign fault_event = (fault_in && !fault_prev) || timer_hit;
  assign pulse_end   = pulse_count >= PULSE_CYCLES - 16'd1;

  always_comb
  begin
    next_pulse_state = pulse_state;
    case (pulse_state)
      charger_pkg::pulse_idle:
        if (fault_event)
          next_pulse_state = charger_pkg::pulse_busy;
      charger_pkg::pulse_busy:
        if (pulse_end)
          next_pulse_state = charger_pkg::pulse_idle;
      default:
        next_pulse_state = charger_pkg::pulse_idle;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_state <= charger_pkg::pulse_idle;
      pulse_count <= 16'h0000;
      fault_prev  <= 1'b0;
    end
    else
    begin
      pulse_state <= next_pulse_state;
      fault_prev  <= fault_in;
      if (pulse_state == charger_pkg::pulse_busy)
        pulse_count <= pulse_count + 16'd1;
      else
        pulse_count <= 16'h0000;
    end
  end

  // -----------------------------------------------------------------------
  // pin and core outputs
  // -----------------------------------------------------------------------
  logic next_stat_oe;
  logic next_boost;
  logic next_limit;

  assign next_stat_oe = en_stat && (charge_in_progress
                        || pulse_state == charger_pkg::pulse_busy);
  // pin request, when enabled, is ORed with the software boost bit; either one turns boost on
  assign next_boost   = (boost_pin_en && sel_sync) || sw_boost;
  assign next_limit   = boost_pin_en ? limit_sel : sel_sync;
  assign stat_out     = 1'b0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_oe       <= 1'b0;
      charge_enable <= 1'b0;
      vbus_hiz      <= 1'b1;
      boost_mode    <= 1'b0;
      limit_500ma   <= 1'b0;
    end
    else
    begin
      stat_oe       <= next_stat_oe;
      charge_enable <= !cd_sync;
      vbus_hiz      <= cd_sync;
      boost_mode    <= next_boost;
      limit_500ma   <= next_limit;
    end
  end

  // -----------------------------------------------------------------------
  // read channel
  // -----------------------------------------------------------------------
  charger_pkg::reg_sel_t rd_sel;
  logic [7:0]            status_word;
  logic [31:0]           rd_word;

  assign arready     = !rvalid;
  assign rd_sel      = reg_decode({araddr[3:2], 2'b00});
  assign status_word = {safety_locked, safety_limit_reset_in_sync, cd_sync, limit_500ma,
                        boost_mode, timer_expired,
                        pulse_state == charger_pkg::pulse_busy,
                        charge_in_progress};
  assign rd_word     = (rd_sel == charger_pkg::sel_control)
                       ? {26'h000_0000, control}
                       : (rd_sel == charger_pkg::sel_status)
                       ? {24'h00_0000, status_word}
                       : (rd_sel == charger_pkg::sel_safety)
                       ? {24'h00_0000, safety_limit}
                       : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= (rd_sel == charger_pkg::sel_none) ? `RESP_SLVERR
                                                  : `RESP_OKAY;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

endmodule

// ===== verif/charger_pin_monitor.sv
// concurrent checks on the charger pin control ports
`timescale 1ns/1ns
`include "charger_defs.svh"
module charger_pin_monitor
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [3:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  // pins and core
  input wire logic        charge_disable_in,
  input wire logic        boost_or_limit_select,
  input wire logic        safety_limit_reset_in,
  input wire logic        stat_oe,
  input wire logic        charge_in_progress,
  input wire logic        fault_in,
  input wire logic        charge_enable,
  input wire logic        vbus_hiz,
  input wire logic        boost_mode,
  input wire logic        limit_500ma,
  input wire logic [7:0]  safety_limit
);
  // ---------------------------------------------------------------------
  // shadow of the control register
  // ---------------------------------------------------------------------
  logic [5:0] ctrl_q;
  wire        ctrl_wr = awvalid && awready && wvalid && wready && wstrb[0]
                        && awaddr == `REG_CONTROL_OFS;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= `CTRL_RESET;
    else if (ctrl_wr)
      ctrl_q <= wdata[5:0];
  end
  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence cd_high4;
    charge_disable_in [*4];
  endsequence
  sequence cd_low4;
    !charge_disable_in [*4];
  endsequence
  sequence fault_idle;
    $rose(fault_in) && !stat_oe && !charge_in_progress && ctrl_q[0];
  endsequence
  cd_stop_a: assert property (cd_high4 |-> vbus_hiz && !charge_enable)
    else $error("disable pin did not stop charging");
  cd_run_a: assert property (cd_low4 |-> !vbus_hiz && charge_enable)
    else $error("charging not enabled with disable pin low");
  limit_sel_a: assert property ((!ctrl_q[2] && $stable(boost_or_limit_select))
    [*4] |-> limit_500ma == boost_or_limit_select)
    else $error("input limit does not follow select pin");
  boost_force_a: assert property ((ctrl_q[2] && boost_or_limit_select)[*4]
    |-> boost_mode)
    else $error("select pin did not force boost");
  boost_off_a: assert property ((!ctrl_q[2] && !ctrl_q[3])[*4]
    |-> !boost_mode)
    else $error("boost active with forcing disabled");
  stat_drive_a: assert property ((ctrl_q[0] && charge_in_progress)[*3]
    |-> stat_oe)
    else $error("status pin not pulled low while charging");
  stat_off_a: assert property ((!ctrl_q[0])[*3] |-> !stat_oe)
    else $error("status pin driven while disabled");
  pulse_start_a: assert property (fault_idle |-> ##2 stat_oe)
    else $error("fault did not start a status pulse");
  safety_hold_a: assert property (!safety_limit_reset_in[*4]
    |-> safety_limit == `SAFETY_RESET)
    else $error("safety limits not held at default");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
endmodule

// ===== verif/charger_host_model.sv
// host model: drives the control pins and reads the status line
`timescale 1ns/1ns
module charger_host_model
(
  // clock
  input wire logic aclk,
  // requested pin levels
  input wire logic want_disable,
  input wire logic want_select,
  input wire logic want_safety_rst,
  // control pins to the device
  output logic     charge_disable_in,
  output logic     boost_or_limit_select,
  output logic     safety_limit_reset_in,
  // open-drain status line
  input wire logic stat_out,
  input wire logic stat_oe,
  output logic     stat_level
);
  // pull-up holds the line high once released
  assign stat_level = stat_oe ? stat_out : 1'b1;
  initial
  begin
    charge_disable_in = 1'b0;
    boost_or_limit_select = 1'b0;
    safety_limit_reset_in = 1'b0;
  end
  always @(posedge aclk)
  begin
    charge_disable_in     <= want_disable;
    boost_or_limit_select <= want_select;
    safety_limit_reset_in <= want_safety_rst;
  end
endmodule

// ===== verif/test_charger_pin_control.sv
// self-checking bench for the charger pin control block
`timescale 1ns/1ns
`include "charger_defs.svh"
module test_charger_pin_control;
  localparam logic [15:0] PULSE = 16'h0010;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, fault_in = 1'b0;
  logic want_disable = 1'b0, want_select = 1'b0, want_safety_rst = 1'b0;
  logic charge_in_progress = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  wire awready, wready, bvalid, arready, rvalid, stat_out, stat_oe;
  wire charge_enable, vbus_hiz, boost_mode, limit_500ma, timer_expired;
  wire charge_disable_in, boost_or_limit_select, safety_limit_reset_in;
  wire stat_level;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] safety_limit;
  int n_fail = 0, comparisons = 0, cycles = 0, n;
  charger_pin_control #(.PULSE_CYCLES(PULSE), .LONG_CYCLES(38'h64),
    .SHORT_CYCLES(38'h28)) dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .charge_disable_in, .boost_or_limit_select,
    .safety_limit_reset_in, .stat_out, .stat_oe, .charge_in_progress,
    .fault_in, .charge_enable, .vbus_hiz, .boost_mode, .limit_500ma,
    .timer_expired, .safety_limit);
  charger_host_model host_u (.aclk, .want_disable, .want_select,
    .want_safety_rst, .charge_disable_in, .boost_or_limit_select,
    .safety_limit_reset_in, .stat_out, .stat_oe, .stat_level);
  always #2 aclk = ~aclk;
  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic summarize;
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // pin change plus model, synchroniser and output lag
  task automatic pins(input logic cd, sel, srst);
    @(posedge aclk);
    want_disable <= cd;
    want_select <= sel;
    want_safety_rst <= srst;
    cyc(6);
  endtask
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial
  begin
    cyc(20);
    aresetn <= 1'b1;
    rd(`REG_CONTROL_OFS, {26'h0, `CTRL_RESET}, `RESP_OKAY);
    rd(`REG_STATUS_OFS, 32'h0000_0000, `RESP_OKAY);
    rd(4'hC, 32'h0000_0000, `RESP_SLVERR);
    wr(4'hC, 32'h0000_00FF, `RESP_SLVERR);
    chk("charge_enable", 32'h1, {31'h0, charge_enable});
    pins(1'b1, 1'b0, 1'b0);
    chk("vbus_hiz", 32'h1, {31'h0, vbus_hiz});
    rd(`REG_STATUS_OFS, 32'h0000_0020, `RESP_OKAY);
    pins(1'b0, 1'b1, 1'b0);
    chk("limit_500ma", 32'h1, {31'h0, limit_500ma});
    chk("boost_mode", 32'h0, {31'h0, boost_mode});
    pins(1'b0, 1'b0, 1'b0);
    chk("limit_500ma", 32'h0, {31'h0, limit_500ma});
    wr(`REG_CONTROL_OFS, 32'h0000_0005, `RESP_OKAY);
    pins(1'b0, 1'b1, 1'b0);
    chk("boost_mode", 32'h1, {31'h0, boost_mode});
    wr(`REG_CONTROL_OFS, 32'h0000_0001, `RESP_OKAY);
    cyc(3);
    chk("boost_mode", 32'h0, {31'h0, boost_mode});
    pins(1'b0, 1'b0, 1'b0);
    wr(`REG_CONTROL_OFS, 32'h0000_001D, `RESP_OKAY);
    cyc(3);
    chk("boost_mode", 32'h1, {31'h0, boost_mode});
    chk("limit_500ma", 32'h1, {31'h0, limit_500ma});
    charge_in_progress <= 1'b1;
    cyc(3);
    chk("stat_level", 32'h0, {31'h0, stat_level});
    wr(`REG_CONTROL_OFS, 32'h0000_0000, `RESP_OKAY);
    cyc(2);
    chk("stat_level", 32'h1, {31'h0, stat_level});
    wr(`REG_CONTROL_OFS, 32'h0000_0001, `RESP_OKAY);
    charge_in_progress <= 1'b0;
    cyc(3);
    chk("stat_level", 32'h1, {31'h0, stat_level});
    fault_in <= 1'b1;
    cyc(3);
    fault_in <= 1'b0;
    n = 0;
    while (stat_level === 1'b0 && n < 100)
    begin
      n++;
      @(posedge aclk);
    end
    chk("pulse length", {16'h0, PULSE}, n);
    wr(`REG_CONTROL_OFS, 32'h0000_0021, `RESP_OKAY);
    charge_in_progress <= 1'b1;
    cyc(60);
    pins(1'b1, 1'b0, 1'b0);
    pins(1'b0, 1'b0, 1'b0);
    cyc(60);
    chk("timer_expired", 32'h0, {31'h0, timer_expired});
    cyc(50);
    chk("timer_expired", 32'h1, {31'h0, timer_expired});
    wr(`REG_CONTROL_OFS, 32'h0000_0003, `RESP_OKAY);
    wr(`REG_STATUS_OFS, 32'h0000_0004, `RESP_OKAY);
    chk("timer_expired", 32'h0, {31'h0, timer_expired});
    cyc(20);
    pins(1'b1, 1'b0, 1'b0);
    pins(1'b0, 1'b0, 1'b0);
    cyc(15);
    chk("timer_expired", 32'h1, {31'h0, timer_expired});
    charge_in_progress <= 1'b0;
    wr(`REG_SAFETY_OFS, 32'h0000_005A, `RESP_OKAY);
    rd(`REG_SAFETY_OFS, 32'h0000_0000, `RESP_OKAY);
    pins(1'b0, 1'b0, 1'b1);
    wr(`REG_SAFETY_OFS, 32'h0000_005A, `RESP_OKAY);
    rd(`REG_SAFETY_OFS, 32'h0000_005A, `RESP_OKAY);
    chk("safety_limit", 32'h0000_005A, {24'h0, safety_limit});
    wr(`REG_CONTROL_OFS, 32'h0000_0001, `RESP_OKAY);
    wr(`REG_SAFETY_OFS, 32'h0000_0033, `RESP_OKAY);
    rd(`REG_SAFETY_OFS, 32'h0000_005A, `RESP_OKAY);
    pins(1'b0, 1'b0, 1'b0);
    rd(`REG_SAFETY_OFS, 32'h0000_0000, `RESP_OKAY);
    pins(1'b0, 1'b0, 1'b1);
    wr(`REG_SAFETY_OFS, 32'h0000_0077, `RESP_OKAY);
    rd(`REG_SAFETY_OFS, 32'h0000_0077, `RESP_OKAY);
    summarize();
  end
endmodule
bind charger_pin_control charger_pin_monitor mon_u (.aclk, .aresetn,
  .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
  .bvalid, .bready, .charge_disable_in, .boost_or_limit_select,
  .safety_limit_reset_in, .stat_oe, .charge_in_progress, .fault_in,
  .charge_enable, .vbus_hiz, .boost_mode, .limit_500ma, .safety_limit);
